//--- fcsm_pkg.sv
// Constants and register map for the fan channel source mux
package fcsm_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] FCSM_OFS_DUTY_1 = 8'h30;
    localparam logic [7:0] FCSM_OFS_DUTY_2 = 8'h31;
    localparam logic [7:0] FCSM_OFS_DUTY_3 = 8'h32;
    localparam logic [7:0] FCSM_OFS_SETUP_1 = 8'h5c;
    localparam logic [7:0] FCSM_OFS_SETUP_2 = 8'h5d;
    localparam logic [7:0] FCSM_OFS_SETUP_3 = 8'h5e;
    localparam logic [7:0] FCSM_OFS_PINFUNC = 8'h7d;

    // ==========================================================
    // Field positions
    localparam int FCSM_BHV_HI = 7;
    localparam int FCSM_BHV_LO = 5;
    localparam int FCSM_INV_BIT = 4;
    localparam int FCSM_PF_PIN2_ALERT = 0;
    localparam int FCSM_PF_SPD4_OT = 1;
    localparam int FCSM_PF_V25_OT = 2;
    localparam int FCSM_PF_V12_VRM = 3;
    localparam int FCSM_PF_OT_OUT = 4;
    localparam int FCSM_PF_CPU_HOT = 7;
    localparam logic [7:0] FCSM_PF_WR_MASK = 8'h1f;

    // ==========================================================
    // Behaviour codes
    localparam logic [2:0] FCSM_BHV_REM1 = 3'h0;
    localparam logic [2:0] FCSM_BHV_LOCAL = 3'h1;
    localparam logic [2:0] FCSM_BHV_REM2 = 3'h2;
    localparam logic [2:0] FCSM_BHV_FULL = 3'h3;
    localparam logic [2:0] FCSM_BHV_OFF = 3'h4;
    localparam logic [2:0] FCSM_BHV_FAST_LR2 = 3'h5;
    localparam logic [2:0] FCSM_BHV_FAST_ALL = 3'h6;
    localparam logic [2:0] FCSM_BHV_MANUAL = 3'h7;

    // Channel indices
    localparam int FCSM_CH_REM1 = 0;
    localparam int FCSM_CH_LOCAL = 1;
    localparam int FCSM_CH_REM2 = 2;

    // ==========================================================
    // Reset values and duty limits
    localparam logic [7:0] FCSM_SETUP_RST = 8'h82;
    localparam logic [7:0] FCSM_PF_RST = 8'h00;
    localparam logic [7:0] FCSM_DUTY_RST = 8'hff;
    localparam logic [7:0] FCSM_DUTY_FULL = 8'hff;
    localparam logic [7:0] FCSM_DUTY_ZERO = 8'h00;

    // Drive waveform step rate
    localparam logic [7:0] FCSM_STEP_DIV = 8'h0f;
    // Last phase step before the waveform period restarts
    localparam logic [7:0] FCSM_PHASE_TOP = 8'hfe;
endpackage

//--- fcsm_curve_if.sv
// Curve parameters and result between the mux top and a curve calculator
`timescale 1ns/1ps
interface fcsm_curve_if;
    logic [7:0] temp;
    logic [7:0] tmin;
    logic [2:0] range_sh;
    logic [7:0] floor_duty;
    logic [7:0] duty;
    modport calc (input temp, input tmin, input range_sh, input floor_duty, output duty);
    modport user (output temp, output tmin, output range_sh, output floor_duty, input duty);
endinterface

//--- fcsm_curve.sv
// Linear duty curve of one temperature channel for one fan output
`timescale 1ns/1ps
module fcsm_curve
    import fcsm_pkg::*;
(
    fcsm_curve_if.calc cv
);
    logic above;
    logic [7:0] diff;
    logic [7:0] span;
    logic [15:0] prod;
    logic [15:0] ramp;
    logic [16:0] total;

    // Each channel judged only against its own turn-on point
    assign above = cv.temp > cv.tmin;
    assign diff = cv.temp - cv.tmin;
    assign span = FCSM_DUTY_FULL - cv.floor_duty;
    assign prod = 16'(diff) * 16'(span);
    // Range is a power of two degrees so no divider is needed
    assign ramp = prod >> cv.range_sh;
    assign total = {9'h000, cv.floor_duty} + {1'b0, ramp};
    // Floor at turn-on, full duty at the top of the range
    assign cv.duty = !above ? FCSM_DUTY_ZERO :
        (total > {9'h000, FCSM_DUTY_FULL}) ? FCSM_DUTY_FULL : total[7:0];
endmodule

//--- fcsm_top.sv
// Fan output source mux: behaviour select, duty registers, pin functions
`timescale 1ns/1ps
module fcsm_top
    import fcsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rd_data,
    input wire logic [2:0][7:0] temp_ch,
    input wire logic [2:0][7:0] tmin_ch,
    input wire logic [2:0][2:0] range_sh_ch,
    input wire logic [2:0][7:0] overtemp_limit_ch,
    input wire logic [2:0][7:0] duty_floor,
    input wire logic alert_n_in,
    input wire logic overtemp_pin_i,
    output logic overtemp_pin_o,
    output logic overtemp_pin_oe_n,
    output logic fan_drive_out_1,
    output logic fan_drive_out_2,
    output logic fan_drive_out_3,
    output logic pin2_is_alert,
    output logic speed4_pin_is_overtemp,
    output logic v25_pin_is_overtemp,
    output logic v12_pin_is_vrm_bit5
);
    // ==========================================================
    // Registers
    logic [2:0][7:0] setup_r;
    logic [2:0][7:0] manual_r;
    logic [2:0][7:0] duty_r;
    logic [7:0] pinfunc_r;
    logic [7:0] rd_nxt;
    logic [2:0] drive_r;
    logic cpu_hot_r;
    logic pin_o_r;
    logic pin_oe_n_r;
    logic [7:0] div_r;
    logic [7:0] phase_r;
    logic step_en;
    logic overtemp;
    logic [2:0] hit_duty;
    logic [2:0] hit_setup;
    logic [2:0][7:0] duty_nxt;
    logic [2:0] drive_nxt;

    assign overtemp = (temp_ch[0] > overtemp_limit_ch[0]) ||
        (temp_ch[1] > overtemp_limit_ch[1]) || (temp_ch[2] > overtemp_limit_ch[2]);
    assign step_en = (div_r == FCSM_STEP_DIV);

    // ==========================================================
    // Per output: curves, source select, drive
    genvar o;
    genvar c;
    generate
        for (o = 0; o < 3; o++) begin : g_out
            logic [2:0] bhv;
            logic [2:0][7:0] cd;
            logic [7:0] max_lr2;
            logic [7:0] max_all;
            logic [7:0] pick;
            for (c = 0; c < 3; c++) begin : g_ch
                fcsm_curve_if cif ();
                // Own floor per output even when channels are shared
                assign cif.temp = temp_ch[c];
                assign cif.tmin = tmin_ch[c];
                assign cif.range_sh = range_sh_ch[c];
                assign cif.floor_duty = duty_floor[o];
                assign cd[c] = cif.duty;
                fcsm_curve u_curve (.cv(cif.calc));
            end
            assign hit_duty[o] = reg_wr_en && (reg_addr == FCSM_OFS_DUTY_1 + 8'(o));
            assign hit_setup[o] = reg_wr_en && (reg_addr == FCSM_OFS_SETUP_1 + 8'(o));
            assign bhv = setup_r[o][FCSM_BHV_HI:FCSM_BHV_LO];
            assign max_lr2 = (cd[FCSM_CH_LOCAL] > cd[FCSM_CH_REM2]) ?
                cd[FCSM_CH_LOCAL] : cd[FCSM_CH_REM2];
            assign max_all = (cd[FCSM_CH_REM1] > max_lr2) ? cd[FCSM_CH_REM1] : max_lr2;
            // Independent selector for every output
            assign pick =
                (bhv == FCSM_BHV_REM1) ? cd[FCSM_CH_REM1] :
                (bhv == FCSM_BHV_LOCAL) ? cd[FCSM_CH_LOCAL] :
                (bhv == FCSM_BHV_REM2) ? cd[FCSM_CH_REM2] :
                (bhv == FCSM_BHV_FULL) ? FCSM_DUTY_FULL :
                (bhv == FCSM_BHV_OFF) ? FCSM_DUTY_ZERO :
                (bhv == FCSM_BHV_FAST_LR2) ? max_lr2 :
                (bhv == FCSM_BHV_FAST_ALL) ? max_all :
                (overtemp ? FCSM_DUTY_FULL : manual_r[o]);
            assign duty_nxt[o] = pick;
            // 0xff holds the line on for the whole period
            assign drive_nxt[o] = (bhv == FCSM_BHV_OFF) ? 1'b0 :
                (((duty_r[o] == FCSM_DUTY_FULL) || (phase_r < duty_r[o]))
                ^ setup_r[o][FCSM_INV_BIT]);

            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    setup_r[o] <= FCSM_SETUP_RST;
                    manual_r[o] <= FCSM_DUTY_RST;
                    duty_r[o] <= FCSM_DUTY_RST;
                    drive_r[o] <= 1'b0;
                end else begin
                    if (hit_setup[o]) begin
                        setup_r[o] <= reg_wdata;
                    end
                    // Writes only land in manual mode
                    if (hit_duty[o] && (bhv == FCSM_BHV_MANUAL)) begin
                        manual_r[o] <= reg_wdata;
                    end
                    duty_r[o] <= duty_nxt[o];
                    drive_r[o] <= drive_nxt[o];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Waveform phase counter with divided step enable
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            div_r <= 8'h00;
            phase_r <= 8'h00;
        end else begin
            div_r <= step_en ? 8'h00 : div_r + 8'h01;
            if (step_en) begin
                // Wraps at 0xfe so 255 steps give a 0.39% grain
                phase_r <= (phase_r == FCSM_PHASE_TOP) ? 8'h00 : phase_r + 8'h01;
            end
        end
    end

    // ==========================================================
    // Pin functions and overtemp pin
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pinfunc_r <= FCSM_PF_RST;
            cpu_hot_r <= 1'b0;
            pin_o_r <= 1'b1;
            pin_oe_n_r <= 1'b1;
        end else begin
            if (reg_wr_en && (reg_addr == FCSM_OFS_PINFUNC)) begin
                pinfunc_r <= reg_wdata & FCSM_PF_WR_MASK;
            end
            // Input mode: low level means the processor runs hot
            cpu_hot_r <= !pinfunc_r[FCSM_PF_OT_OUT] && !overtemp_pin_i;
            // Open drain: pull low only while hot, else release
            pin_o_r <= 1'b0;
            pin_oe_n_r <= !(pinfunc_r[FCSM_PF_OT_OUT] && overtemp);
        end
    end

    // ==========================================================
    // Register read, one cycle after the address
    assign rd_nxt =
        (reg_addr == FCSM_OFS_DUTY_1) ? duty_r[0] :
        (reg_addr == FCSM_OFS_DUTY_2) ? duty_r[1] :
        (reg_addr == FCSM_OFS_DUTY_3) ? duty_r[2] :
        (reg_addr == FCSM_OFS_SETUP_1) ? setup_r[0] :
        (reg_addr == FCSM_OFS_SETUP_2) ? setup_r[1] :
        (reg_addr == FCSM_OFS_SETUP_3) ? setup_r[2] :
        (reg_addr == FCSM_OFS_PINFUNC) ? (pinfunc_r | {cpu_hot_r, 7'h00}) : 8'h00;

    logic pin2_r;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rd_data <= 8'h00;
            pin2_r <= 1'b0;
        end else begin
            reg_rd_data <= rd_nxt;
            pin2_r <= pinfunc_r[FCSM_PF_PIN2_ALERT] ? alert_n_in : drive_r[1];
        end
    end

    assign fan_drive_out_1 = drive_r[0];
    assign fan_drive_out_2 = pin2_r;
    assign fan_drive_out_3 = drive_r[2];
    assign overtemp_pin_o = pin_o_r;
    assign overtemp_pin_oe_n = pin_oe_n_r;
    assign pin2_is_alert = pinfunc_r[FCSM_PF_PIN2_ALERT];
    assign speed4_pin_is_overtemp = pinfunc_r[FCSM_PF_SPD4_OT];
    assign v25_pin_is_overtemp = pinfunc_r[FCSM_PF_V25_OT];
    assign v12_pin_is_vrm_bit5 = pinfunc_r[FCSM_PF_V12_VRM];
endmodule

//--- fcsm_top_properties.sv
// Port-level properties of the fan channel source mux
`timescale 1ns/1ps
module fcsm_top_properties
    import fcsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rd_data,
    input wire logic overtemp_pin_oe_n,
    input wire logic fan_drive_out_1,
    input wire logic fan_drive_out_3,
    input wire logic pin2_is_alert,
    input wire logic speed4_pin_is_overtemp,
    input wire logic v25_pin_is_overtemp,
    input wire logic v12_pin_is_vrm_bit5
);
    // ==========================================================
    // Setup mirrors, rebuilt from the write traffic
    logic [7:0] s1_r;
    logic [7:0] s3_r;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s1_r <= FCSM_SETUP_RST;
            s3_r <= FCSM_SETUP_RST;
        end else if (reg_wr_en) begin
            if (reg_addr == FCSM_OFS_SETUP_1) s1_r <= reg_wdata;
            if (reg_addr == FCSM_OFS_SETUP_3) s3_r <= reg_wdata;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ==========================================================
    // Properties
    reset_values_a: assert property (
        $fell(srst) |-> reg_rd_data == 8'h00 && !fan_drive_out_1 && overtemp_pin_oe_n)
        else $error("outputs wrong after reset");
    setup_readback_a: assert property (
        reg_wr_en && reg_addr == FCSM_OFS_SETUP_1 ##1 reg_addr == FCSM_OFS_SETUP_1
        |=> reg_rd_data == $past(reg_wdata, 2)) else $error("setup readback mismatch");
    pin_function_a: assert property (
        reg_wr_en && reg_addr == FCSM_OFS_PINFUNC |=> {v12_pin_is_vrm_bit5,
        v25_pin_is_overtemp, speed4_pin_is_overtemp, pin2_is_alert} == $past(reg_wdata[3:0]))
        else $error("pin function levels mismatch");
    off_drive_a: assert property (
        (s1_r[7:5] == FCSM_BHV_OFF)[*4] |-> !fan_drive_out_1) else $error("disabled output drives");
    full_drive_a: assert property (
        ($stable(s3_r) && s3_r[7:5] == FCSM_BHV_FULL)[*4] |-> fan_drive_out_3 == !s3_r[4])
        else $error("full speed output not at full level");
    off_duty_a: assert property (
        (s1_r[7:5] == FCSM_BHV_OFF)[*3] ##1 reg_addr == FCSM_OFS_DUTY_1
        |=> reg_rd_data == FCSM_DUTY_ZERO) else $error("disabled duty not zero");
    full_duty_a: assert property (
        (s3_r[7:5] == FCSM_BHV_FULL)[*3] ##1 reg_addr == FCSM_OFS_DUTY_3
        |=> reg_rd_data == FCSM_DUTY_FULL) else $error("full speed duty not 0xff");
    unmapped_read_a: assert property (
        reg_addr == 8'h40 |=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
endmodule

bind fcsm_top fcsm_top_properties u_props (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .overtemp_pin_oe_n(overtemp_pin_oe_n),
    .fan_drive_out_1(fan_drive_out_1), .fan_drive_out_3(fan_drive_out_3),
    .pin2_is_alert(pin2_is_alert), .speed4_pin_is_overtemp(speed4_pin_is_overtemp),
    .v25_pin_is_overtemp(v25_pin_is_overtemp), .v12_pin_is_vrm_bit5(v12_pin_is_vrm_bit5)
);

//--- fcsm_fan_model.sv
// Fan stand-in that totals cycles of high drive on each output
`timescale 1ns/1ps
module fcsm_fan_model (
    input wire logic clk_sys,
    input wire logic [2:0] drive,
    output logic [2:0][15:0] hi_cnt
);
    // Fans only integrate the drive; nothing flows back to the mux
    initial hi_cnt = '0;
    always @(posedge clk_sys) begin
        for (int i = 0; i < 3; i++) hi_cnt[i] <= hi_cnt[i] + 16'(drive[i]);
    end
endmodule

//--- fan_channel_source_mux_bench.sv
// Self-checking bench for the fan channel source mux
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module fan_channel_source_mux_bench import fcsm_pkg::*;;
    logic clk_sys = 0, srst = 1, reg_wr_en = 0, alert_n_in = 1, ot_i = 1, rd_req = 0, pend = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rd_data, v, ev;
    logic [2:0][7:0] temp_ch = '0, tmin_ch, limit, floor_d;
    logic [2:0][2:0] sh;
    logic ot_o, oe_n, fo1, fo2, fo3, p2a, s4, v25, v12;
    logic [2:0][15:0] hi;
    logic [2:0] cd [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [7:0] expq [$];
    int err_count = 0, samples_checked = 0, k, e, o;
    always #2 clk_sys = ~clk_sys;
    fcsm_top u_dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .temp_ch(temp_ch), .tmin_ch(tmin_ch),
        .range_sh_ch(sh), .overtemp_limit_ch(limit), .duty_floor(floor_d), .alert_n_in(alert_n_in),
        .overtemp_pin_i(ot_i), .overtemp_pin_o(ot_o), .overtemp_pin_oe_n(oe_n),
        .fan_drive_out_1(fo1), .fan_drive_out_2(fo2), .fan_drive_out_3(fo3), .pin2_is_alert(p2a),
        .speed4_pin_is_overtemp(s4), .v25_pin_is_overtemp(v25), .v12_pin_is_vrm_bit5(v12));
    fcsm_fan_model u_fans (.clk_sys(clk_sys), .drive({fo3, fo2, fo1}), .hi_cnt(hi));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1;
        @(posedge clk_sys) #1;
        reg_wr_en = 0;
    endtask
    // Expectation is queued here; the monitor pops it when the data lands
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk_sys) #1;
        reg_addr = a;
        rd_req = 1;
        expq.push_back(ex);
        @(posedge clk_sys) #1;
        rd_req = 0;
    endtask
    always @(posedge clk_sys) begin
        if (pend) begin
            ev = expq.pop_front();
            `CHK("reg_rd_data", ev, reg_rd_data)
        end
        pend <= rd_req;
    end
    function automatic logic [7:0] crv(input int c, input int f);
        int d;
        d = 0;
        if (temp_ch[c] > tmin_ch[c])
            d = int'(floor_d[f]) + (((int'(temp_ch[c]) - int'(tmin_ch[c]))
                * (255 - int'(floor_d[f]))) >> sh[c]);
        return (d > 255) ? 8'hff : d[7:0];
    endfunction
    function automatic logic [7:0] mx(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction
    function automatic logic [7:0] expd(input logic [2:0] c, input int f);
        case (c)
            3'h0: return crv(0, f);
            3'h1: return crv(1, f);
            3'h2: return crv(2, f);
            3'h5: return mx(crv(1, f), crv(2, f));
            default: return mx(crv(0, f), mx(crv(1, f), crv(2, f)));
        endcase
    endfunction
    task automatic finish_test;
        $display("err_count %0d samples_checked %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        finish_test;
    end
    initial begin
        void'($urandom(32'hf802));
        tmin_ch = {8'h28, 8'h1e, 8'h32};
        limit = {3{8'hff}};
        sh = {3'h3, 3'h4, 3'h5};
        floor_d = {8'h66, 8'h33, 8'h80};
        repeat (10) @(posedge clk_sys);
        #1 srst = 0;
        for (o = 0; o < 3; o++) begin
            rd(8'(FCSM_OFS_SETUP_1 + o), FCSM_SETUP_RST);
            rd(8'(FCSM_OFS_DUTY_1 + o), FCSM_DUTY_ZERO);
        end
        rd(8'h40, 8'h00);
        wr(FCSM_OFS_DUTY_1, 8'h40);
        rd(FCSM_OFS_DUTY_1, 8'h00);
        wr(FCSM_OFS_SETUP_1, 8'h60);
        wr(FCSM_OFS_SETUP_3, 8'h70);
        repeat (4) @(posedge clk_sys);
        k = hi[0];
        e = hi[2] + hi[1];
        repeat (32) @(posedge clk_sys);
        `CHK("fan1 high cycles", 32, int'(hi[0]) - k)
        `CHK("fan2 fan3 high cycles", 0, int'(hi[2] + hi[1]) - e)
        rd(FCSM_OFS_DUTY_3, FCSM_DUTY_FULL);
        wr(FCSM_OFS_SETUP_1, 8'he0);
        v = 8'($urandom);
        wr(FCSM_OFS_DUTY_1, v);
        repeat (2) @(posedge clk_sys);
        rd(FCSM_OFS_DUTY_1, v);
        limit[0] = 8'h50;
        temp_ch[0] = 8'h60;
        repeat (3) @(posedge clk_sys);
        rd(FCSM_OFS_DUTY_1, FCSM_DUTY_FULL);
        limit = {3{8'hff}};
        for (k = 0; k < 5; k++) begin
            for (o = 0; o < 3; o++) temp_ch[o] = 8'($urandom_range(8'hc0, 8'h10));
            for (o = 0; o < 3; o++) wr(8'(FCSM_OFS_SETUP_1 + o), {cd[(k + o) % 5], 5'h00});
            repeat (4) @(posedge clk_sys);
            for (o = 0; o < 3; o++)
                rd(8'(FCSM_OFS_DUTY_1 + o), expd(cd[(k + o) % 5], o));
        end
        // All outputs on one channel; distinct floors must give distinct duties
        temp_ch[FCSM_CH_REM1] = 8'($urandom_range(8'h50, 8'h38));
        for (o = 0; o < 3; o++) wr(8'(FCSM_OFS_SETUP_1 + o), {FCSM_BHV_REM1, 5'h00});
        repeat (4) @(posedge clk_sys);
        for (o = 0; o < 3; o++) rd(8'(FCSM_OFS_DUTY_1 + o), crv(FCSM_CH_REM1, o));
        v = 8'($urandom_range(15, 0));
        wr(FCSM_OFS_PINFUNC, {4'he, v[3:0]});
        repeat (2) @(posedge clk_sys);
        `CHK("pin functions", v[3:0], {v12, v25, s4, p2a})
        rd(FCSM_OFS_PINFUNC, {4'h0, v[3:0]});
        ot_i = 0;
        repeat (2) @(posedge clk_sys);
        rd(FCSM_OFS_PINFUNC, {4'h8, v[3:0]});
        wr(FCSM_OFS_PINFUNC, 8'h10);
        limit[1] = 8'h08;
        repeat (4) @(posedge clk_sys);
        `CHK("overtemp_pin_oe_n", 1'b0, oe_n)
        `CHK("overtemp_pin_o", 1'b0, ot_o)
        // Shared pin 2 carries the alert level; both levels so the drive cannot mask it
        wr(FCSM_OFS_PINFUNC, 8'h01);
        alert_n_in = 1'($urandom);
        repeat (2) @(posedge clk_sys);
        `CHK("fan_drive_out_2", alert_n_in, fo2)
        #1 alert_n_in = ~alert_n_in;
        repeat (2) @(posedge clk_sys);
        `CHK("fan_drive_out_2", alert_n_in, fo2)
        repeat (2) @(posedge clk_sys);
        finish_test;
    end
endmodule
